// ### prot_defines.svh
/*
  constants of the drive protection selector: register offsets, field
  positions, reset values and timing figures.
  assumes a 20 MHz system clock and a 32-bit AHB-Lite register bus.
*/
`ifndef PROT_DEFINES_SVH
`define PROT_DEFINES_SVH

`define CLK_KHZ            20000
`define INLOSS_TIME_MS     1000
`define GND_CHECK_TIME_MS  20

`define OFS_CTRL           8'h00
`define OFS_VIS            8'h04
`define OFS_STATUS         8'h08
`define OFS_MASK           8'h0c
`define OFS_FAULT          8'h10
`define OFS_THERMAL        8'h14
`define OFS_CMD            8'h18

`define EN_OUTLOSS         0
`define EN_INLOSS          1
`define EN_GND             2
`define CTRL_RESET         3'h1
`define VIS_RESET          8'h00

`define TRIP_OUTLOSS       0
`define TRIP_INLOSS        1
`define TRIP_GND           2
`define TRIP_PE            3

`define FAULT_FIRST_LSB    4
`define FAULT_FIRST_V      8
`define FAULT_PE_PWRON     9
`define CMD_MRESET         0

`endif

// ### prot_pkg.sv
/*
  types of the drive protection selector.
  assumes prot_defines.svh is compiled alongside.
*/
package prot_pkg;

  typedef enum logic [1:0] {GND_IDLE, GND_CHECK, GND_RUN} gnd_state_type;

  typedef struct packed {
    logic run;
    logic start_cmd;
    logic dc_brake;
    logic freq_low;
    logic out_lost;
    logic in_lost;
    logic regen;
    logic light_load;
    logic gnd_fault;
    logic param_fault;
    logic thermal_tick;
    logic retry_req;
  } sense_type;

  typedef struct packed {
    logic [31:0] count;
    logic        done;
  } timer_state_type;

  typedef struct packed {
    gnd_state_type gst;
    logic [2:0]    en;
    logic [7:0]    vis;
    logic [3:0]    trip;
    logic [3:0]    status;
    logic [3:0]    mask;
    logic [3:0]    first;
    logic          first_v;
    logic          pe_pwron;
    logic          pwron;
    logic [31:0]   thermal;
    logic [31:0]   rdata;
    logic [7:0]    waddr;
    logic          wr;
    logic          start_d;
  } main_state_type;

endpackage

// ### persist_timer.sv
/*
  persistence timer: done rises once run has held for CYCLES edges.
  assumes run is synchronous to hclk; dropping run restarts the count.
*/
`timescale 1ns/1ns
module persist_timer #(
  parameter int CYCLES = 1
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // control
  input  wire logic run,
  output logic      done
);

  prot_pkg::timer_state_type state_reg;
  prot_pkg::timer_state_type state_next;

  always_comb
  begin
    state_next = state_reg;
    if (!run)
    begin
      state_next.count = 32'h0;
      state_next.done  = 1'b0;
    end
    else if (!state_reg.done)
    begin
      state_next.count = state_reg.count + 32'h1;
      state_next.done  = (state_reg.count >= 32'(CYCLES - 1));
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign done = state_reg.done;

endmodule // persist_timer

// ### prot_select.sv
/*
  drive protection selector: output phase loss, input phase loss and
  start-time earth fault checks, latched trips, retry bookkeeping and an
  AHB-Lite register slave with a read-clear interrupt status.
  assumes sense inputs are synchronous to hclk and retry_req is a pulse.
*/
`timescale 1ns/1ns
`include "prot_defines.svh"

// Summary of operation
// RULE1: output phase loss trips while running above 1Hz
// RULE2: output loss enable 0 off, 1 on
// RULE3: input loss trips after 1s continuous loss
// RULE4: input loss enable only on three-phase variant
// RULE5: no input loss flag while regenerating
// RULE6: no input loss detect light load/stopped
// RULE7: earth check only right after start command
// RULE8: earth fault while running never trips
// RULE9: output held about 20ms during earth check
// RULE10: earth fault at start trips, stops output
// RULE11: earth check enable 0 off, 1 on
// RULE12: retry record keeps only first fault
// RULE13: retry keeps thermal data, power-on clears
// RULE14: no retry after power-on storage fault
// RULE15: enables writable only while visibility is 0
// RULE16: trips latch, inhibit output until reset
module prot_select #(
  parameter bit THREE_PHASE    = 1'b1,
  parameter int INLOSS_CYCLES  = `INLOSS_TIME_MS * `CLK_KHZ,
  parameter int GND_CYCLES     = `GND_CHECK_TIME_MS * `CLK_KHZ
) (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [7:0]           haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  // power stage sensing
  input  wire prot_pkg::sense_type  sense,
  // drive control
  output logic                      drive_inhibit,
  output logic                      output_allow,
  output logic [3:0]                trip_code,
  output logic                      irq
);

  prot_pkg::main_state_type s_reg;
  prot_pkg::main_state_type s_next;

  logic       inl_run;
  logic       inl_done;
  logic       gnd_done;
  logic       outl_hit;
  logic       gnd_hit;
  logic       mreset;
  logic       retry_ok;
  logic       addr_ph;
  logic [3:0] trip_set;
  logic [3:0] trip_new;

  // input loss needs fluctuation: load, running, not regenerating
  assign inl_run = THREE_PHASE && s_reg.en[`EN_INLOSS] && sense.in_lost && sense.run //RULE4
                   && !sense.regen //RULE5
                   && !sense.light_load; //RULE6

  persist_timer #(
    .CYCLES (INLOSS_CYCLES)
  ) u_inloss (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (inl_run),
    .done    (inl_done)
  );

  persist_timer #(
    .CYCLES (GND_CYCLES)
  ) u_gnd (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (s_reg.gst == prot_pkg::GND_CHECK),
    .done    (gnd_done)
  );

  assign outl_hit = s_reg.en[`EN_OUTLOSS] && sense.run && sense.out_lost //RULE2
                    && !sense.dc_brake && !sense.freq_low; //RULE1
  assign gnd_hit  = (s_reg.gst == prot_pkg::GND_CHECK) && sense.gnd_fault; //RULE8
  assign mreset   = s_reg.wr && (s_reg.waddr == `OFS_CMD) && hwdata[`CMD_MRESET];
  assign retry_ok = sense.retry_req && (|s_reg.trip) && !s_reg.pe_pwron; //RULE14
  assign addr_ph  = hsel && hready && htrans[1];

  always_comb
  begin
    trip_set = 4'h0;
    trip_set[`TRIP_OUTLOSS] = outl_hit; //RULE1
    trip_set[`TRIP_INLOSS]  = inl_done; //RULE3
    trip_set[`TRIP_GND]     = gnd_hit; //RULE10
    trip_set[`TRIP_PE]      = sense.param_fault;
  end

  assign trip_new = trip_set & ~s_reg.trip;

  always_comb
  begin
    s_next = s_reg;
    s_next.start_d = sense.start_cmd;
    // trips hold until manual reset or accepted retry
    if (mreset || retry_ok)
      s_next.trip = trip_set; //RULE16
    else
      s_next.trip = s_reg.trip | trip_set; //RULE16
    // first fault since last manual reset is kept
    if (mreset)
    begin
      // a fault landing with the reset is kept, set wins
      s_next.first_v = |trip_set; //RULE12
      s_next.first   = trip_set; //RULE12
    end
    else if (!s_reg.first_v && (|trip_new))
    begin
      s_next.first_v = 1'b1; //RULE12
      s_next.first   = trip_new; //RULE12
    end
    // storage fault seen before the first start blocks retries
    if (sense.param_fault && s_reg.pwron)
      s_next.pe_pwron = 1'b1;
    else if (mreset)
      s_next.pe_pwron = 1'b0;
    // thermal accumulation survives retries, only power-on clears it
    if (sense.thermal_tick)
      s_next.thermal = s_reg.thermal + 32'h1; //RULE13
    // start sequencing with earth check window
    unique case (s_reg.gst)
      prot_pkg::GND_IDLE:
        if (sense.start_cmd && !s_reg.start_d && !(|s_reg.trip))
        begin
          s_next.pwron = 1'b0;
          if (s_reg.en[`EN_GND]) //RULE11
            s_next.gst = prot_pkg::GND_CHECK; //RULE7
          else
            s_next.gst = prot_pkg::GND_RUN;
        end
      prot_pkg::GND_CHECK:
        if (!sense.start_cmd || gnd_hit || (|s_reg.trip))
          s_next.gst = prot_pkg::GND_IDLE;
        else if (gnd_done)
          s_next.gst = prot_pkg::GND_RUN; //RULE9
      prot_pkg::GND_RUN:
        if (!sense.start_cmd || (|s_reg.trip))
          s_next.gst = prot_pkg::GND_IDLE;
    endcase
    // bus data phase writes
    s_next.wr = 1'b0;
    if (s_reg.wr)
    begin
      unique case (s_reg.waddr)
        `OFS_CTRL:
          if (s_reg.vis == 8'h00) //RULE15
          begin
            s_next.en = hwdata[2:0];
            s_next.en[`EN_INLOSS] = hwdata[`EN_INLOSS] & THREE_PHASE; //RULE4
          end
        `OFS_VIS:  s_next.vis  = hwdata[7:0];
        `OFS_MASK: s_next.mask = hwdata[3:0];
        default:   s_next.vis  = s_reg.vis;
      endcase
    end
    // status: new trips set, read clears, set wins
    s_next.status = s_reg.status | trip_new;
    if (addr_ph)
    begin
      s_next.wr    = hwrite;
      s_next.waddr = {haddr[7:2], 2'b00};
      s_next.rdata = 32'h0;
      if (!hwrite)
      begin
        unique case ({haddr[7:2], 2'b00})
          `OFS_CTRL:    s_next.rdata = {29'h0, s_reg.en};
          `OFS_VIS:     s_next.rdata = {24'h0, s_reg.vis};
          `OFS_STATUS:
          begin
            s_next.rdata  = {28'h0, s_reg.status};
            s_next.status = trip_new;
          end
          `OFS_MASK:    s_next.rdata = {28'h0, s_reg.mask};
          `OFS_FAULT:   s_next.rdata = {22'h0, s_reg.pe_pwron, s_reg.first_v, s_reg.first, s_reg.trip};
          `OFS_THERMAL: s_next.rdata = s_reg.thermal;
          default:      s_next.rdata = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_reg         <= '0;
      s_reg.gst     <= prot_pkg::GND_IDLE;
      s_reg.en      <= `CTRL_RESET;
      s_reg.vis     <= `VIS_RESET;
      s_reg.pwron   <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = s_reg.rdata;
  assign drive_inhibit = |s_reg.trip; //RULE16
  assign output_allow  = (s_reg.gst == prot_pkg::GND_RUN) && !drive_inhibit; //RULE9
  assign trip_code     = s_reg.trip;
  assign irq           = |(s_reg.status & s_reg.mask);

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_outloss_trip: assert property (outl_hit |=> s_reg.trip[`TRIP_OUTLOSS] && drive_inhibit) //RULE1
    else $error("output loss did not trip");
  chk_outloss_disabled: assert property ($rose(s_reg.trip[`TRIP_OUTLOSS]) |-> $past(s_reg.en[`EN_OUTLOSS])) //RULE2
    else $error("output loss tripped while disabled");
  chk_inloss_persist: assert property ($rose(s_reg.trip[`TRIP_INLOSS]) |-> $past(inl_done, 1)) //RULE3
    else $error("input loss tripped without persistence");
  chk_inloss_variant: assert property (!THREE_PHASE |-> !s_reg.en[`EN_INLOSS] && !s_reg.trip[`TRIP_INLOSS]) //RULE4
    else $error("input loss active on single-phase variant");
  chk_inloss_regen: assert property (sense.regen |=> !inl_done) //RULE5
    else $error("input loss timer ran while regenerating");
  chk_inloss_light: assert property ((sense.light_load || !sense.run) |=> !inl_done) //RULE6
    else $error("input loss timer ran on light load");
  chk_gnd_window: assert property ($rose(s_reg.trip[`TRIP_GND]) |-> $past(s_reg.gst == prot_pkg::GND_CHECK)) //RULE7
    else $error("earth fault tripped outside start check");
  chk_gnd_running: assert property (s_reg.gst == prot_pkg::GND_RUN && sense.gnd_fault && !s_reg.trip[`TRIP_GND]
                                    && !mreset && !retry_ok |=> !s_reg.trip[`TRIP_GND]) //RULE8
    else $error("earth fault tripped while running");
  chk_gnd_hold: assert property (s_reg.gst == prot_pkg::GND_CHECK |-> !output_allow) //RULE9
    else $error("output allowed during earth check");
  chk_gnd_trip: assert property (gnd_hit |=> s_reg.trip[`TRIP_GND] ##1 !output_allow) //RULE10
    else $error("earth fault at start did not trip");
  chk_gnd_enable: assert property (s_reg.gst == prot_pkg::GND_IDLE ##1 s_reg.gst == prot_pkg::GND_CHECK
                                   |-> $past(s_reg.en[`EN_GND])) //RULE11
    else $error("earth check entered while disabled");
  chk_first_keep: assert property (s_reg.first_v && !mreset |=> s_reg.first_v && $stable(s_reg.first)) //RULE12
    else $error("first fault record overwritten");
  chk_thermal_keep: assert property (retry_ok && !sense.thermal_tick |=> $stable(s_reg.thermal)) //RULE13
    else $error("retry disturbed thermal data");
  chk_pe_no_retry: assert property (s_reg.pe_pwron && s_reg.trip[`TRIP_PE] && !mreset |=> s_reg.trip[`TRIP_PE]) //RULE14
    else $error("retry cleared power-on storage fault");
  chk_vis_lock: assert property (s_reg.vis != 8'h00 |=> $stable(s_reg.en)) //RULE15
    else $error("enables changed while locked");
  chk_trip_latch: assert property (|s_reg.trip && !mreset && !retry_ok |=> (s_reg.trip & $past(s_reg.trip))
                                   == $past(s_reg.trip)) //RULE16
    else $error("trip released without reset");
  chk_mreset_clear: assert property (mreset |=> s_reg.trip == $past(trip_set)) //RULE16
    else $error("manual reset left a stale trip");
  chk_retry_clear: assert property (retry_ok |=> s_reg.trip == $past(trip_set)) //RULE16
    else $error("accepted retry left a stale trip");
  chk_start_refused: assert property (s_reg.gst == prot_pkg::GND_IDLE && (|s_reg.trip)
                                      |=> s_reg.gst == prot_pkg::GND_IDLE) //RULE16
    else $error("start accepted while tripped");
  chk_inloss_trip: assert property (inl_done |=> s_reg.trip[`TRIP_INLOSS]) //RULE3
    else $error("input loss persisted without trip");
  chk_pe_flag: assert property (sense.param_fault && s_reg.pwron |=> s_reg.pe_pwron) //RULE14
    else $error("power-on storage fault not flagged");
  chk_status_sticky: assert property (|trip_new |=> (s_reg.status & $past(trip_new)) == $past(trip_new))
    else $error("new trip missing from status");
  chk_status_clear: assert property (addr_ph && !hwrite && {haddr[7:2], 2'b00} == `OFS_STATUS
                                     && trip_new == 4'h0 |=> s_reg.status == 4'h0)
    else $error("status not cleared by read");

  cov_outloss: cover property (outl_hit ##1 s_reg.trip[`TRIP_OUTLOSS]);
  cov_gnd_pass: cover property (s_reg.gst == prot_pkg::GND_CHECK ##1 s_reg.gst == prot_pkg::GND_RUN);
  cov_retry: cover property (retry_ok ##1 !drive_inhibit);
  cov_irq: cover property ($rose(irq));

endmodule // prot_select

// ### phase_sense_model.sv
/*
  model of the power stage sensing: turns the wanted motor and mains
  conditions into the registered sense bundle of the selector.
  assumes the bench changes want just after a rising edge of hclk.
*/
`timescale 1ns/1ns
module phase_sense_model (
  // clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // wanted conditions and sensed result
  input  wire prot_pkg::sense_type want,
  output prot_pkg::sense_type      sense
);
  prot_pkg::sense_type prev_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_reg <= '0;
      sense    <= '0;
    end
    else
    begin
      prev_reg           <= want;
      sense              <= want;
      // pulses last one cycle per request
      sense.thermal_tick <= want.thermal_tick & ~prev_reg.thermal_tick;
      sense.retry_req    <= want.retry_req & ~prev_reg.retry_req;
    end
  end
endmodule // phase_sense_model

// ### testbench.sv
/*
  self-checking bench of the protection selector: table of trip cases,
  then earth check, interrupt, lock, retry and reset cases.
  assumes prot_pkg and phase_sense_model are compiled first.
*/
`timescale 1ns/1ns
module testbench;
  typedef struct packed {logic [2:0] ctrl; logic [11:0] s; logic [3:0] exp;} row_type;
  logic                hclk = 1'b0;
  logic                hresetn = 1'b0;
  logic                hsel = 1'b0;
  logic                hwrite = 1'b0;
  logic [7:0]          haddr = 8'h00;
  logic [1:0]          htrans = 2'h0;
  logic [2:0]          hsize = 3'h2;
  logic [31:0]         hwdata = 32'h0;
  logic                hreadyout, hresp, drive_inhibit, output_allow, irq;
  logic [31:0]         hrdata, rd;
  logic [3:0]          trip_code;
  prot_pkg::sense_type want = '0;
  prot_pkg::sense_type sense;
  int                  error_cnt = 0;
  int                  compares = 0;
  row_type             rows [9];

  always #25 hclk = ~hclk;

  phase_sense_model phase_sense_model_inst (.hclk(hclk), .hresetn(hresetn), .want(want), .sense(sense));

  prot_select #(.THREE_PHASE(1'b1), .INLOSS_CYCLES(20), .GND_CYCLES(10)) prot_select_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sense(sense), .drive_inhibit(drive_inhibit), .output_allow(output_allow),
    .trip_code(trip_code), .irq(irq));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // one single word transfer, read data left in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic set_want(input logic [11:0] v);
    @(posedge hclk);
    want <= v;
  endtask

  // drop every cause, then manual fault reset
  task automatic clear_all;
    set_want(12'h000);
    cyc(2);
    bus(1'b1, 8'h18, 32'h1);
  endtask

  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    cyc(20000);
    error_cnt++;
    final_report();
  end

  initial
  begin
    rows = '{{3'h1, 12'h880, 4'h1}, {3'h1, 12'ha80, 4'h0}, {3'h1, 12'h980, 4'h0},
             {3'h0, 12'h880, 4'h0}, {3'h2, 12'h840, 4'h2}, {3'h2, 12'h860, 4'h0},
             {3'h2, 12'h850, 4'h0}, {3'h2, 12'h040, 4'h0}, {3'h0, 12'h840, 4'h0}};
    cyc(20);
    @(posedge hclk) hresetn <= 1'b1;
    chk("trip_code", {28'h0, trip_code}, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    chk("hreadyout", {31'h0, hreadyout}, 32'h1);
    bus(1'b0, 8'h00, 32'h0);
    chk("ctrl", rd, 32'h1);
    bus(1'b0, 8'h3c, 32'h0);
    chk("unmapped", rd, 32'h0);
    repeat (3)
    begin
      set_want(12'h002);
      set_want(12'h000);
    end
    bus(1'b1, 8'h0c, 32'hf);
    $display("reset test done");
    foreach (rows[i])
    begin
      clear_all();
      bus(1'b1, 8'h00, {29'h0, rows[i].ctrl});
      set_want(rows[i].s | 12'h400);
      cyc(40);
      chk("row trip", {28'h0, trip_code}, {28'h0, rows[i].exp});
      chk("row inhibit", {31'h0, drive_inhibit}, {31'h0, |rows[i].exp});
      chk("row allow", {31'h0, output_allow}, {31'h0, rows[i].exp == 4'h0});
      $display("row %0d done", i);
    end
    chk("irq set", {31'h0, irq}, 32'h1);
    bus(1'b0, 8'h08, 32'h0);
    chk("status", rd, 32'h3);
    bus(1'b0, 8'h08, 32'h0);
    chk("status cleared", rd, 32'h0);
    chk("irq clear", {31'h0, irq}, 32'h0);
    clear_all();
    bus(1'b1, 8'h0c, 32'h0);
    bus(1'b1, 8'h00, 32'h4);
    set_want(12'hc00);
    cyc(5);
    chk("allow in check", {31'h0, output_allow}, 32'h0);
    cyc(10);
    chk("allow after check", {31'h0, output_allow}, 32'h1);
    set_want(12'hc08);
    cyc(5);
    chk("earth while running", {28'h0, trip_code}, 32'h0);
    set_want(12'h000);
    cyc(2);
    set_want(12'hc08);
    cyc(15);
    chk("earth at start", {28'h0, trip_code}, 32'h4);
    chk("earth allow", {31'h0, output_allow}, 32'h0);
    chk("irq masked", {31'h0, irq}, 32'h0);
    bus(1'b1, 8'h0c, 32'h4);
    bus(1'b0, 8'h0c, 32'h0);
    chk("mask", rd, 32'h4);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    clear_all();
    bus(1'b1, 8'h00, 32'h0);
    set_want(12'hc08);
    cyc(15);
    chk("earth off", {28'h0, trip_code}, 32'h0);
    $display("earth test done");
    bus(1'b1, 8'h04, 32'h1);
    bus(1'b0, 8'h04, 32'h0);
    chk("vis", rd, 32'h1);
    bus(1'b1, 8'h00, 32'h7);
    bus(1'b0, 8'h00, 32'h0);
    chk("ctrl locked", rd, 32'h0);
    bus(1'b1, 8'h04, 32'h0);
    bus(1'b1, 8'h00, 32'h7);
    bus(1'b0, 8'h00, 32'h0);
    chk("ctrl open", rd, 32'h7);
    clear_all();
    bus(1'b1, 8'h00, 32'h2);
    set_want(12'hc40);
    cyc(15);
    set_want(12'hc00);
    set_want(12'hc40);
    cyc(15);
    chk("inloss broken", {28'h0, trip_code}, 32'h0);
    cyc(15);
    chk("inloss held", {28'h0, trip_code}, 32'h2);
    $display("input loss test done");
    clear_all();
    bus(1'b1, 8'h00, 32'h1);
    set_want(12'hc80);
    cyc(5);
    set_want(12'h404);
    cyc(3);
    chk("second fault", {28'h0, trip_code}, 32'h9);
    set_want(12'h400);
    cyc(2);
    set_want(12'h401);
    cyc(3);
    chk("retry clears", {28'h0, trip_code}, 32'h0);
    bus(1'b0, 8'h10, 32'h0);
    chk("first fault", {27'h0, rd[8:4]}, 32'h11);
    bus(1'b0, 8'h14, 32'h0);
    chk("thermal kept", rd, 32'h3);
    $display("retry test done");
    set_want(12'h000);
    @(posedge hclk) hresetn <= 1'b0;
    cyc(3);
    @(posedge hclk) hresetn <= 1'b1;
    bus(1'b0, 8'h14, 32'h0);
    chk("thermal cleared", rd, 32'h0);
    set_want(12'h004);
    cyc(3);
    set_want(12'h000);
    cyc(2);
    set_want(12'h001);
    cyc(3);
    chk("no retry", {28'h0, trip_code}, 32'h8);
    bus(1'b0, 8'h10, 32'h0);
    chk("power-on flag", {31'h0, rd[9]}, 32'h1);
    $display("power-on test done");
    final_report();
  end
endmodule // testbench
